// file: design/dpba_pkg.sv
package dpba_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES = 2;

  // Device timing figures, in nanoseconds.
  localparam int T_FLAG_FROM_MATCH_NS = 45;
  localparam int CONTENTION_FLAG_FROM_SELECT_NS = 40;
  localparam int CONTENTION_RELEASE_FROM_DESELECT_NS = 35;
  localparam int CONTENTION_INPUT_TO_WRITE_NS = 0;
  localparam int WRITE_HOLD_AFTER_CONTENTION_NS = 25;
  localparam int T_WRITE_PULSE_NS = 25;
  localparam int T_RELEASE_TO_DATA_NS = 45;
  localparam int T_STROBE_TO_DATA_NS = 95;
  localparam int T_DATA_TO_DATA_NS = 80;

  function automatic int dpba_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dpba_cyc_up

  function automatic int dpba_cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dpba_cyc_dn

  function automatic int dpba_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : dpba_max

  localparam int FLAG_SETTLE_CYC = dpba_max(dpba_cyc_dn(T_FLAG_FROM_MATCH_NS),
                                            dpba_cyc_dn(CONTENTION_FLAG_FROM_SELECT_NS));
  localparam int SETTLE_CYC = FLAG_SETTLE_CYC + SYNC_STAGES;
  localparam int INPUT_LEAD_CYC = dpba_cyc_up(CONTENTION_INPUT_TO_WRITE_NS);
  localparam int WRITE_HOLD_CYC = dpba_cyc_up(WRITE_HOLD_AFTER_CONTENTION_NS);
  localparam int WRITE_CYC = dpba_max(dpba_cyc_up(T_WRITE_PULSE_NS), WRITE_HOLD_CYC);
  localparam int READ_CYC = dpba_cyc_up(T_RELEASE_TO_DATA_NS) + SYNC_STAGES;
  localparam int RELEASE_CYC = dpba_cyc_up(CONTENTION_RELEASE_FROM_DESELECT_NS);
  localparam int POST_CYC = dpba_max(dpba_cyc_up(T_STROBE_TO_DATA_NS), dpba_cyc_up(T_DATA_TO_DATA_NS));
  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

endpackage : dpba_pkg

// file: design/dpba_sync.sv
module dpba_sync import dpba_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dpba_sync_t;

  dpba_sync_t st_r;
  dpba_sync_t st_nxt;

  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  // Idle pins are high, so the flops start high to avoid a false strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule : dpba_sync

// file: design/dpba_host_port.sv
// Contract
// RULE1: Device grants the port settling first, given the arbitration setup margin.
// RULE2: Near-simultaneous contention still flags busy on exactly one side.
// RULE3: In slave configuration the device makes no winner decision itself.
// RULE4: In slave mode busy input must be asserted before write strobe starts.
// RULE5: Keep write strobe active the hold time after busy releases.
// RULE6: That hold applies in both master and slave configuration.
// RULE7: Master flags busy within the address-match delay.
// RULE8: Master releases busy within the delay after addresses stop matching.
// RULE9: Master flags busy within the delay after enable falls on a match.
// RULE10: Master releases busy within the delay after the enable rises.
// RULE11: Written data reaches the other port within the strobe-to-data delay.
// RULE12: Written data reaches the other port within the data-to-data delay.
// RULE13: Read data is valid within the bound after busy releases.
// RULE14: Select makes busy pins outputs on master, inputs on slave.
// RULE15: Writes on a port driven busy by a master are ignored internally.
// RULE16: Busy is never low on both ports; high unless enabled on a match.
module dpba_host_port import dpba_pkg::*; #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // User request side.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // Board straps and cascade.
  input wire logic slave_mode,
  input wire logic cascade_busy_n,
  // Memory port pins.
  output logic ce_n,
  output logic rw_n,
  output logic oe_n,
  output logic [AW-1:0] addr,
  input wire logic [DW-1:0] dq_i,
  output logic [DW-1:0] dq_o,
  output logic dq_oe,
  input wire logic busy_n_i,
  output logic busy_n_o,
  output logic busy_n_oe
);

  if (AW < 1 || DW < 1 || POST_CYC > 15 || SETTLE_CYC > 15 || READ_CYC > 15) begin : g_chk
    $error("dpba_host_port: widths or cycle counts out of range");
  end

  typedef enum {ST_IDLE, ST_SETTLE, ST_WRITE, ST_POST, ST_READ} dpba_state_t;

  typedef struct packed {
    dpba_state_t st;
    logic [CNT_W-1:0] cnt;
    logic write;
    logic slave;
    logic ce_n;
    logic rw_n;
    logic oe_n;
    logic dq_oe;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic rsp;
  } dpba_host_t;

  dpba_host_t st_r;
  dpba_host_t st_nxt;
  logic mode_s;
  logic master_s;
  logic casc_s;
  logic busy_s;
  logic [DW-1:0] dq_s;
  logic cont;

  dpba_sync #(
    .WIDTH(DW + 3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({!slave_mode, cascade_busy_n, busy_n_i, dq_i}),
    .sync_out({master_s, casc_s, busy_s, dq_s})
  );

  // The strap is inverted through the synchroniser so that its reset level means master.
  // Otherwise the busy pin would be driven against the device for two cycles after reset.
  assign mode_s = !master_s;

  // The host treats the cascade busy as its own contention on a slave. [RULE3] [RULE14]
  // Either side may lose the race, so every access waits out its own flag. [RULE1] [RULE2] [RULE16]
  assign cont = st_r.slave ? !casc_s : !busy_s;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp = 1'b0;
    case (st_r.st)
      ST_IDLE: begin
        if (req_valid) begin
          st_nxt.write = req_write;
          st_nxt.addr = req_addr;
          st_nxt.wdata = req_wdata;
          st_nxt.ce_n = 1'b0;
          st_nxt.oe_n = req_write;
          st_nxt.cnt = CNT_W'(SETTLE_CYC);
          st_nxt.st = ST_SETTLE;
        end else begin
          st_nxt.slave = mode_s;
        end
      end
      // Wait for the device busy flag to show through the synchroniser. [RULE7] [RULE9]
      ST_SETTLE: begin
        if (st_r.cnt != CNT_ZERO) begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end else if (st_r.write) begin
          st_nxt.rw_n = 1'b0;
          st_nxt.dq_oe = 1'b1;
          st_nxt.cnt = CNT_W'(WRITE_CYC);
          st_nxt.st = ST_WRITE;
        end else begin
          st_nxt.cnt = CNT_W'(READ_CYC);
          st_nxt.st = ST_READ;
        end
      end
      // Contention restarts the count, so the strobe outlasts busy by the hold time. [RULE5] [RULE6] [RULE15]
      ST_WRITE: begin
        if (cont) begin
          st_nxt.cnt = CNT_W'(WRITE_CYC);
        end else if (st_r.cnt != CNT_ONE) begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end else begin
          st_nxt.rw_n = 1'b1;
          st_nxt.cnt = CNT_W'(dpba_max(POST_CYC, RELEASE_CYC));
          st_nxt.st = ST_POST;
        end
      end
      // Done is held back until the opposite port can see the data. [RULE11] [RULE12] [RULE10]
      ST_POST: begin
        st_nxt.dq_oe = 1'b0;
        st_nxt.ce_n = 1'b1;
        if (st_r.cnt != CNT_ONE) begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end else begin
          st_nxt.rsp = 1'b1;
          st_nxt.st = ST_IDLE;
        end
      end
      // Data is taken only after busy has been gone for the release-to-data bound. [RULE13] [RULE8]
      ST_READ: begin
        if (cont) begin
          st_nxt.cnt = CNT_W'(READ_CYC);
        end else if (st_r.cnt != CNT_ONE) begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end else begin
          st_nxt.rdata = dq_s;
          st_nxt.ce_n = 1'b1;
          st_nxt.oe_n = 1'b1;
          st_nxt.rsp = 1'b1;
          st_nxt.st = ST_IDLE;
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.st <= ST_IDLE;
      st_r.cnt <= CNT_ZERO;
      st_r.write <= 1'b0;
      st_r.slave <= 1'b0;
      st_r.ce_n <= 1'b1;
      st_r.rw_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.dq_oe <= 1'b0;
      st_r.addr <= '0;
      st_r.wdata <= '0;
      st_r.rdata <= '0;
      st_r.rsp <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req_ready = (st_r.st == ST_IDLE);
  assign rsp_valid = st_r.rsp;
  assign rsp_rdata = st_r.rdata;
  assign ce_n = st_r.ce_n;
  assign rw_n = st_r.rw_n;
  assign oe_n = st_r.oe_n;
  assign addr = st_r.addr;
  assign dq_o = st_r.wdata;
  assign dq_oe = st_r.dq_oe;
  // On a slave the host drives the busy pin from the cascade master. [RULE4] [RULE14]
  assign busy_n_oe = st_r.slave;
  assign busy_n_o = casc_s;

  slave_lead_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    $fell(rw_n) && busy_n_oe |-> $past(busy_n_oe, INPUT_LEAD_CYC) && $stable(busy_n_o))
    else $error("write strobe started before slave busy was driven");

  write_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    $rose(rw_n) |-> $past(!cont, WRITE_HOLD_CYC) && $past(!ce_n, 1))
    else $error("write strobe ended inside the hold window after busy");

  mode_drive_a: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    st_r.st != ST_IDLE |-> $stable(busy_n_oe))
    else $error("busy pin direction changed during an access");

  strobe_enable_a: assert property (@(posedge clk) disable iff (rst) // [RULE15]
    !rw_n |-> !ce_n && dq_oe && oe_n)
    else $error("write strobe without chip enable or driven data");

  settle_wait_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    $fell(ce_n) |-> (rw_n && oe_n == st_r.write)[*3])
    else $error("strobe issued before busy could settle");

  read_wait_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    rsp_valid && !st_r.write |-> $past(!cont, 1) && $past(!cont, 2) && $past(!cont, 3))
    else $error("read data taken too soon after busy release");

  post_wait_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    $rose(rw_n) |-> !rsp_valid[*2])
    else $error("write reported done before port to port delay");

  ready_idle_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    req_ready |-> ce_n && rw_n && !dq_oe)
    else $error("port still enabled while idle");

endmodule : dpba_host_port

// file: sim/dpba_ram_model.sv
module dpba_ram_model (
  // Clock.
  input wire logic clk,
  // Host port pins.
  input wire logic ce_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wdata_oe,
  output logic [15:0] rdata,
  // Contention pin and strap.
  input wire logic slave,
  input wire logic busy_in,
  output logic busy_n,
  // Opposite port, driven by the bench.
  input wire logic other_ce_n,
  input wire logic [11:0] other_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [4096];
  logic [15:0] last_r = 16'h0000;
  logic win_r = 1'b0;
  logic match;
  logic inhibit;
  assign match = !ce_n && !other_ce_n && (addr == other_addr);
  // The host keeps priority only if it was enabled before the match formed.
  always @(posedge clk) begin
    if (!match) begin
      win_r <= !ce_n;
    end
  end
  assign busy_n = slave || !(match && !win_r);
  assign inhibit = slave ? !busy_in : !busy_n;
  always @(posedge clk) begin
    if (!ce_n && !rw_n && wdata_oe && !inhibit) begin
      mem[addr] <= wdata;
    end
    last_r <= rdata;
  end
  // A released bus toggles so that stale data never passes for a read.
  assign rdata = (!ce_n && !oe_n && rw_n) ? mem[addr] : ~last_r;
endmodule : dpba_ram_model

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("mismatch %0t %s", $time, m); end end
  logic clk, rst, req_valid, req_ready, req_write, rsp_valid, slave_mode, cascade_busy_n;
  logic ce_n, rw_n, oe_n, dq_oe, busy_n_o, busy_n_oe, m_busy_n, busy_pin, other_ce_n, hold_off;
  logic [11:0] req_addr, addr, other_addr, a;
  logic [15:0] req_wdata, rsp_rdata, dq_o, m_rdata, dq_w, d;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  assign dq_w = dq_oe ? dq_o : m_rdata;
  assign busy_pin = busy_n_oe ? busy_n_o : m_busy_n;
  dpba_host_port i_dpba_host_port (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .slave_mode(slave_mode), .cascade_busy_n(cascade_busy_n), .ce_n(ce_n),
    .rw_n(rw_n), .oe_n(oe_n), .addr(addr), .dq_i(dq_w), .dq_o(dq_o), .dq_oe(dq_oe), .busy_n_i(busy_pin),
    .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe));
  dpba_ram_model i_dpba_ram_model (.clk(clk), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr),
    .wdata(dq_o), .wdata_oe(dq_oe), .rdata(m_rdata), .slave(slave_mode), .busy_in(busy_pin),
    .busy_n(m_busy_n), .other_ce_n(other_ce_n), .other_addr(other_addr));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic issue(input logic wr, input logic [11:0] ra, input logic [15:0] wd, input logic [15:0] ex);
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= ra;
    req_wdata <= wd;
    exp_q.push_back({!wr, ex});
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : issue
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
    if (rsp_valid === 1'b1) begin
      `CHK(hold_off, 1'b0, "access finished under contention")
      if (exp_q.size() == 0) begin
        `CHK(1'b0, 1'b1, "unexpected response")
      end else begin
        note = exp_q.pop_front();
        if (note[16]) `CHK(rsp_rdata, note[15:0], "read data")
      end
    end
  end
  initial begin
    rst = 1'b1;
    {req_valid, req_write, slave_mode, hold_off} = 4'h0;
    {cascade_busy_n, other_ce_n} = 2'h3;
    {req_addr, other_addr, req_wdata} = 40'h0;
    void'($urandom(32'hbd2923ac));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({ce_n, rw_n, oe_n, dq_oe, busy_n_oe, req_ready}, 6'h39, "reset state")
    for (int i = 0; i < 6; i++) begin
      a = (i < 2) ? {12{i[0]}} : 12'($urandom);
      d = 16'($urandom);
      issue(1'b1, a, d, 16'h0000);
      issue(1'b0, a, 16'h0000, d);
    end
    // Opposite port holds the address first, so the host write must wait.
    while (exp_q.size() != 0) @(posedge clk);
    d = ~d;
    other_ce_n <= 1'b0;
    other_addr <= a;
    hold_off <= 1'b1;
    issue(1'b1, a, d, 16'h0000);
    repeat (20) @(posedge clk);
    `CHK(busy_pin, 1'b0, "busy while matched")
    hold_off <= 1'b0;
    other_addr <= ~a;
    issue(1'b0, a, 16'h0000, d);
    // Contended read released by the opposite enable rising.
    issue(1'b1, a, 16'h0000, 16'h0000);
    while (exp_q.size() != 0) @(posedge clk);
    other_addr <= a;
    hold_off <= 1'b1;
    issue(1'b0, a, 16'h0000, 16'h0000);
    repeat (20) @(posedge clk);
    hold_off <= 1'b0;
    other_ce_n <= 1'b1;
    // The host enabled first keeps priority.
    issue(1'b0, a, 16'h0000, 16'h0000);
    repeat (2) @(posedge clk);
    other_ce_n <= 1'b0;
    issue(1'b1, a, d, 16'h0000);
    other_ce_n <= 1'b1;
    // Slave strap: the write waits on the cascaded busy input.
    issue(1'b0, a, 16'h0000, d);
    while (exp_q.size() != 0) @(posedge clk);
    slave_mode <= 1'b1;
    repeat (5) @(posedge clk);
    cascade_busy_n <= 1'b0;
    hold_off <= 1'b1;
    issue(1'b1, a, ~d, 16'h0000);
    repeat (20) @(posedge clk);
    `CHK({busy_n_oe, busy_n_o}, 2'h2, "busy driven in slave mode")
    hold_off <= 1'b0;
    cascade_busy_n <= 1'b1;
    issue(1'b0, a, 16'h0000, ~d);
    while (exp_q.size() != 0) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top
